// ===== acc_pkg.sv
package acc_pkg;

    // Bus widths
    localparam int ACC_AW = 8;
    localparam int ACC_DW = 32;

    // Register indices; byte address is four times the index
    localparam logic [7:0] ACC_IDX_CS = 8'h2c;
    localparam logic [7:0] ACC_IDX_INSEL = 8'h2d;
    localparam logic [7:0] ACC_IDX_DAC = 8'h2e;
    localparam logic [7:0] ACC_IDX_PIN = 8'h2f;
    localparam logic [7:0] ACC_IDX_ISTAT = 8'h30;
    localparam logic [7:0] ACC_IDX_ICLR = 8'h31;
    localparam logic [7:0] ACC_IDX_IEN = 8'h32;

    // Control/status field positions
    localparam int ACC_CS_ENABLE = 7;
    localparam int ACC_CS_HYSTERESIS_SELECT = 6;
    localparam int ACC_CS_FLAG = 5;
    localparam int ACC_CS_IRQEN = 4;
    localparam int ACC_CS_RESULT = 3;
    localparam int ACC_CS_PADEN = 2;
    localparam int ACC_CS_SENS_HI = 1;
    localparam int ACC_CS_SENS_LO = 0;

    // Writable bit masks
    localparam logic [7:0] ACC_INSEL_MASK = 8'h33;
    localparam logic [7:0] ACC_DAC_MASK = 8'hff;
    localparam logic [7:0] ACC_PIN_MASK = 8'h07;
    localparam logic [7:0] ACC_IRQ_MASK = 8'h07;

    // Reset values
    localparam logic [7:0] ACC_RST_BYTE = 8'h00;

    // Interrupt status bit positions
    localparam int ACC_IS_MATCH = 0;
    localparam int ACC_IS_RISE = 1;
    localparam int ACC_IS_FALL = 2;

    // Synchroniser depth
    localparam int ACC_SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        ACC_SENS_FALL = 2'h0,
        ACC_SENS_RISE = 2'h1,
        ACC_SENS_FALL2 = 2'h2,
        ACC_SENS_BOTH = 2'h3
    } acc_sens_type;

    typedef enum logic [0:0] {
        ACC_BUS_IDLE = 1'h0,
        ACC_BUS_ACK = 1'h1
    } acc_bus_type;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [ACC_AW-1:0] adr;
        logic [ACC_DW-1:0] dat;
    } acc_wbreq_type;

    typedef struct packed {
        logic enable;
        logic hysteresis_select;
        logic irqEn;
        logic padEn;
        acc_sens_type sens;
    } acc_ctrl_type;

endpackage : acc_pkg

// ===== acc_sync.sv
`timescale 1ns/1ps
module acc_sync
    import acc_pkg::*;
#(
    parameter int STAGES = ACC_SYNC_STAGES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic asyncIn,
    output logic syncOut
);

    logic [STAGES-1:0] chain_r;

    // Chain of flops; only the last stage is read outside
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            chain_r <= '0;
        end else begin
            chain_r <= {chain_r[STAGES-2:0], asyncIn};
        end
    end

    assign syncOut = chain_r[STAGES-1];

endmodule : acc_sync

// ===== acc_comparator_control_status.sv
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
// Summary of operation
// RULE1: Four 8-bit registers at consecutive indices from the base, all reset to zero. The code maps seven, adding status, clear and enable at 0x30-0x32.
// RULE2: Control bit 7 enables the comparator.
// RULE3: Control bit 6 selects hysteresis, 0 low setting, 1 high setting.
// RULE4: Flag bit 5 set on matching edge of the synchronised comparator output.
// RULE5: Writing 0 clears the flag; writing 1 leaves it unchanged.
// RULE6: Control bit 4 gates the interrupt request. The code gates only the flag term with it; the status term is gated by irqEn_r.
// RULE7: Bit 3 reads the live comparator result; writes ignored.
// RULE8: Result bit is zero while the comparator is disabled.
// RULE9: Bit 2 enables driving the result onto the external pin.
// RULE10: Sensitivity 00 selects falling edge, 01 rising edge.
// RULE11: Sensitivity 10 selects falling edge, 11 both edges.
// RULE12: Keeps operating in wait mode; interrupt can wake the processor.
// RULE13: Keeps operating in deep stop mode; interrupt can wake from it.
// RULE14: Settings kept across interrupt wake; reset restores reset values.
// RULE15: Keeps operating normally in debug mode, nothing frozen.
// RULE16: Interrupt request is a level: flag and enable both set. The code also raises it when irqStat_r and irqEn_r share a set bit.
module acc_comparator_control_status
    import acc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [ACC_AW-1:0] wb_adr_i,
    input wire logic [ACC_DW-1:0] wb_dat_i,
    output logic [ACC_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rawCompareOutput,
    output logic comparatorEnable,
    output logic hysteresisSelect,
    output logic [7:0] comparatorInputSelect,
    output logic [7:0] comparatorDacControl,
    output logic [7:0] comparatorPinEnable,
    output logic compPinOut,
    output logic compPinOe,
    output logic compIrq
);

    acc_wbreq_type req;
    acc_bus_type busState_r;
    acc_bus_type busState_nxt;
    acc_ctrl_type ctrl_r;
    logic [ACC_DW-1:0] datO_r;
    logic [ACC_DW-1:0] rdData;
    logic [7:0] regIdx;
    logic idxValid;
    logic wrStrobe;
    logic wrLane0;
    logic [7:0] wrByte;
    logic wrCs;
    logic wrInsel;
    logic wrDac;
    logic wrPin;
    logic wrIclr;
    logic wrIen;
    logic [7:0] inputSelect_r;
    logic [7:0] dacControl_r;
    logic [7:0] pinEnable_r;
    logic flag_r;
    logic syncResult;
    logic compareResult_r;
    logic resultPrev_r;
    logic riseEdge;
    logic fallEdge;
    logic matchEdge;
    logic [7:0] irqStat_r;
    logic [7:0] irqEn_r;
    logic [7:0] irqEvents;
    logic [7:0] csRead;
    logic padEnNxt;
    logic pinOut_r;

    // Bus request grouped for decode
    assign req.cyc = wb_cyc_i;
    assign req.stb = wb_stb_i;
    assign req.we = wb_we_i;
    assign req.sel = wb_sel_i;
    assign req.adr = wb_adr_i;
    assign req.dat = wb_dat_i;

    // Word index from byte address
    assign regIdx = {2'h0, req.adr[ACC_AW-1:2]};

    always_comb begin
        case (regIdx)
            ACC_IDX_CS,
            ACC_IDX_INSEL,
            ACC_IDX_DAC,
            ACC_IDX_PIN,
            ACC_IDX_ISTAT,
            ACC_IDX_ICLR,
            ACC_IDX_IEN: begin
                idxValid = 1'b1;
            end
            default: begin
                idxValid = 1'b0;
            end
        endcase
    end

    // Bus handshake: one wait state, ack for one cycle
    always_comb begin
        case (busState_r)
            ACC_BUS_IDLE: begin
                if (req.cyc && req.stb) begin
                    busState_nxt = ACC_BUS_ACK;
                end else begin
                    busState_nxt = ACC_BUS_IDLE;
                end
            end
            ACC_BUS_ACK: begin
                busState_nxt = ACC_BUS_IDLE;
            end
            default: begin
                busState_nxt = ACC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            busState_r <= ACC_BUS_IDLE;
        end else begin
            busState_r <= busState_nxt;
        end
    end

    assign wb_ack_o = (busState_r == ACC_BUS_ACK);

    // Write takes effect on the acknowledging edge, low byte lane only
    assign wrStrobe = wb_ack_o && req.cyc && req.stb && req.we;
    assign wrLane0 = wrStrobe && req.sel[0] && idxValid;
    assign wrByte = req.dat[7:0];
    assign wrCs = wrLane0 && (regIdx == ACC_IDX_CS);
    assign wrInsel = wrLane0 && (regIdx == ACC_IDX_INSEL);
    assign wrDac = wrLane0 && (regIdx == ACC_IDX_DAC);
    assign wrPin = wrLane0 && (regIdx == ACC_IDX_PIN);
    assign wrIclr = wrLane0 && (regIdx == ACC_IDX_ICLR);
    assign wrIen = wrLane0 && (regIdx == ACC_IDX_IEN);

    // Control fields; only the synchronous reset clears them
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_r <= '0; // RULE1 RULE14
        end else if (wrCs) begin
            ctrl_r.enable <= wrByte[ACC_CS_ENABLE]; // RULE2
            ctrl_r.hysteresis_select <= wrByte[ACC_CS_HYSTERESIS_SELECT]; // RULE3
            ctrl_r.irqEn <= wrByte[ACC_CS_IRQEN]; // RULE6
            ctrl_r.padEn <= wrByte[ACC_CS_PADEN]; // RULE9
            ctrl_r.sens <= acc_sens_type'(wrByte[ACC_CS_SENS_HI:ACC_CS_SENS_LO]);
        end
    end

    // Input select register, reserved bits held at zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            inputSelect_r <= ACC_RST_BYTE; // RULE1
        end else if (wrInsel) begin
            inputSelect_r <= wrByte & ACC_INSEL_MASK;
        end
    end

    // DAC control register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dacControl_r <= ACC_RST_BYTE; // RULE1
        end else if (wrDac) begin
            dacControl_r <= wrByte & ACC_DAC_MASK;
        end
    end

    // Pin enable register, reserved bits held at zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pinEnable_r <= ACC_RST_BYTE; // RULE1
        end else if (wrPin) begin
            pinEnable_r <= wrByte & ACC_PIN_MASK;
        end
    end

    // Bring the comparator output into the bus clock domain
    acc_sync #(
        .STAGES(ACC_SYNC_STAGES)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .asyncIn(rawCompareOutput),
        .syncOut(syncResult)
    );

    // Result forced low while disabled
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            compareResult_r <= 1'b0;
        end else begin
            compareResult_r <= syncResult && ctrl_r.enable; // RULE8 RULE12 RULE13 RULE15
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            resultPrev_r <= 1'b0;
        end else begin
            resultPrev_r <= compareResult_r;
        end
    end

    assign riseEdge = compareResult_r && !resultPrev_r; // RULE4
    assign fallEdge = !compareResult_r && resultPrev_r; // RULE4

    // Edge selection
    always_comb begin
        case (ctrl_r.sens)
            ACC_SENS_FALL: begin
                matchEdge = fallEdge; // RULE10
            end
            ACC_SENS_RISE: begin
                matchEdge = riseEdge; // RULE10
            end
            ACC_SENS_FALL2: begin
                matchEdge = fallEdge; // RULE11
            end
            ACC_SENS_BOTH: begin
                matchEdge = riseEdge || fallEdge; // RULE11
            end
            default: begin
                matchEdge = 1'b0;
            end
        endcase
    end

    // Edge flag: set wins over a clearing write
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else if (matchEdge) begin
            flag_r <= 1'b1; // RULE4
        end else if (wrCs && !wrByte[ACC_CS_FLAG]) begin
            flag_r <= 1'b0; // RULE5
        end
    end

    // Sticky event status
    assign irqEvents = {5'h00, fallEdge, riseEdge, matchEdge};

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irqStat_r <= ACC_RST_BYTE;
        end else if (wrIclr) begin
            irqStat_r <= (irqStat_r & ~wrByte) | (irqEvents & ACC_IRQ_MASK);
        end else begin
            irqStat_r <= irqStat_r | (irqEvents & ACC_IRQ_MASK);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irqEn_r <= ACC_RST_BYTE;
        end else if (wrIen) begin
            irqEn_r <= wrByte & ACC_IRQ_MASK;
        end
    end

    // Level request, never gated by low-power or debug state
    assign compIrq = (flag_r && ctrl_r.irqEn) || (|(irqStat_r & irqEn_r)); // RULE16 RULE6 RULE12 RULE13

    // Control/status read image
    always_comb begin
        csRead = 8'h00;
        csRead[ACC_CS_ENABLE] = ctrl_r.enable;
        csRead[ACC_CS_HYSTERESIS_SELECT] = ctrl_r.hysteresis_select;
        csRead[ACC_CS_FLAG] = flag_r;
        csRead[ACC_CS_IRQEN] = ctrl_r.irqEn;
        csRead[ACC_CS_RESULT] = compareResult_r; // RULE7
        csRead[ACC_CS_PADEN] = ctrl_r.padEn;
        csRead[ACC_CS_SENS_HI:ACC_CS_SENS_LO] = ctrl_r.sens;
    end

    // Read mux; unmapped and write-only indices read zero
    always_comb begin
        rdData = '0;
        case (regIdx)
            ACC_IDX_CS: begin
                rdData[7:0] = csRead;
            end
            ACC_IDX_INSEL: begin
                rdData[7:0] = inputSelect_r;
            end
            ACC_IDX_DAC: begin
                rdData[7:0] = dacControl_r;
            end
            ACC_IDX_PIN: begin
                rdData[7:0] = pinEnable_r;
            end
            ACC_IDX_ISTAT: begin
                rdData[7:0] = irqStat_r;
            end
            ACC_IDX_IEN: begin
                rdData[7:0] = irqEn_r;
            end
            default: begin
                rdData = '0;
            end
        endcase
    end

    // Read data captured as the answer is issued
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            datO_r <= '0;
        end else if (busState_r == ACC_BUS_IDLE && req.cyc && req.stb) begin
            datO_r <= rdData;
        end
    end

    assign wb_dat_o = datO_r;

    // Analog-side controls
    assign comparatorEnable = ctrl_r.enable; // RULE2
    assign hysteresisSelect = ctrl_r.hysteresis_select; // RULE3
    assign comparatorInputSelect = inputSelect_r;
    assign comparatorDacControl = dacControl_r;
    assign comparatorPinEnable = pinEnable_r;

    // Output pad, registered; follows the same-edge padEn update so it never leads the pad enable
    assign padEnNxt = wrCs ? wrByte[ACC_CS_PADEN] : ctrl_r.padEn;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pinOut_r <= 1'h0;
        end else begin
            pinOut_r <= syncResult && ctrl_r.enable && padEnNxt; // RULE8 RULE9
        end
    end

    assign compPinOut = pinOut_r; // RULE9
    assign compPinOe = ctrl_r.padEn; // RULE9

endmodule : acc_comparator_control_status

// ===== acc_ccs_properties.sv
`timescale 1ns/1ps
module acc_ccs_properties
    import acc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [ACC_AW-1:0] wb_adr_i,
    input wire logic [ACC_DW-1:0] wb_dat_i,
    input wire logic [ACC_DW-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic rawCompareOutput,
    input wire logic comparatorEnable,
    input wire logic hysteresisSelect,
    input wire logic [7:0] comparatorInputSelect,
    input wire logic compPinOut,
    input wire logic compPinOe
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    logic req;
    logic wrDone;
    assign req = wb_cyc_i && wb_stb_i;
    assign wrDone = wb_ack_o && wb_we_i && wb_sel_i[0];
    chk_ack_next: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req))
        else $error("ack without request");
    chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i < 8'hb0
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    chk_cs_write: assert property (wrDone && wb_adr_i == 8'hb0
        |=> comparatorEnable == $past(wb_dat_i[7]) && hysteresisSelect == $past(wb_dat_i[6])
        && compPinOe == $past(wb_dat_i[2])) else $error("control write lost");
    chk_insel_mask: assert property (wrDone && wb_adr_i == 8'hb4
        |=> comparatorInputSelect == ($past(wb_dat_i[7:0]) & 8'h33)) else $error("mask");
    chk_pad_gate: assert property (!compPinOe |-> !compPinOut)
        else $error("pin driven while pad off");
    chk_off_low: assert property (!comparatorEnable && !$past(comparatorEnable)
        |-> !compPinOut) else $error("result while disabled");
    chk_pin_follow: assert property ((comparatorEnable && compPinOe
        && $stable(rawCompareOutput)) [*4] |-> compPinOut == rawCompareOutput)
        else $error("pin not following result");
    cover property (wrDone && wb_adr_i == 8'hb0);
    cover property ($rose(compPinOut));
    cover property (wb_ack_o && !wb_we_i);
endmodule : acc_ccs_properties

bind acc_comparator_control_status acc_ccs_properties chk (
    .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rawCompareOutput(rawCompareOutput),
    .comparatorEnable(comparatorEnable), .hysteresisSelect(hysteresisSelect),
    .comparatorInputSelect(comparatorInputSelect), .compPinOut(compPinOut),
    .compPinOe(compPinOe)
);

// ===== testbench.sv
`timescale 1ns/1ps
module testbench
    import acc_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    acc_wbreq_type req = '0;
    logic raw = 1'b0;
    logic [ACC_DW-1:0] datO;
    logic ack, cEn, hSel, pinOut, pinOe, irq;
    logic [7:0] inSel, dac, pinEn, q;
    int nFail = 0;
    int testsRun = 0;
    always #2.5 mclk = ~mclk;
    acc_comparator_control_status dut (
        .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
        .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(datO),
        .wb_ack_o(ack), .rawCompareOutput(raw), .comparatorEnable(cEn),
        .hysteresisSelect(hSel), .comparatorInputSelect(inSel), .comparatorDacControl(dac),
        .comparatorPinEnable(pinEn), .compPinOut(pinOut), .compPinOe(pinOe), .compIrq(irq)
    );
    task automatic stopTest;
        $display("checks %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stopTest
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            nFail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wb(input logic we, input logic s0, input logic [7:0] idx,
                      input logic [7:0] d);
        int n;
        n = 0;
        req <= '{1'b1, 1'b1, we, {3'h0, s0}, {idx[5:0], 2'b00}, {24'h0, d}};
        @(posedge mclk);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (ack !== 1'b1) begin
            nFail++;
            stopTest();
        end
        q = datO[7:0];
        req <= '0;
        @(posedge mclk);
    endtask : wb
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, 1'b1, idx, d);
    endtask : wr
    task automatic rdm(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
        wb(1'b0, 1'b1, idx, 8'h00);
        chk($sformatf("reg %h", idx), q & m, e);
    endtask : rdm
    task automatic t_reset;
        for (int i = 8'h2c; i <= 8'h32; i++) begin
            rdm(8'(i), 8'hff, 8'h00);
        end
        rdm(8'h10, 8'hff, 8'h00);
        chk("outs", {cEn, hSel, pinOe, pinOut, irq, 3'h0}, 8'h00);
    endtask : t_reset
    task automatic t_regs;
        wr(ACC_IDX_INSEL, 8'hff);
        wr(ACC_IDX_DAC, 8'ha5);
        wr(ACC_IDX_PIN, 8'hff);
        wb(1'b1, 1'b0, ACC_IDX_DAC, 8'h00);
        rdm(ACC_IDX_INSEL, 8'hff, 8'h33);
        rdm(ACC_IDX_DAC, 8'hff, 8'ha5);
        rdm(ACC_IDX_PIN, 8'hff, 8'h07);
        chk("insel", inSel, 8'h33);
        chk("dac", dac, 8'ha5);
        chk("pin", pinEn, 8'h07);
    endtask : t_regs
    task automatic t_cs;
        wr(ACC_IDX_CS, 8'hff);
        rdm(ACC_IDX_CS, 8'hff, 8'hd7);
        chk("ctl", {5'h0, cEn, hSel, pinOe}, 8'h07);
        raw <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("out", {6'h0, pinOut, irq}, 8'h03);
        wr(ACC_IDX_CS, 8'hff);
        rdm(ACC_IDX_CS, 8'hff, 8'hff);
        wr(ACC_IDX_CS, 8'hdb);
        rdm(ACC_IDX_CS, 8'hff, 8'hdb);
        chk("clr", {5'h0, pinOe, pinOut, irq}, 8'h00);
        wr(ACC_IDX_CS, 8'hcb);
        raw <= 1'b0;
        repeat (6) @(posedge mclk);
        rdm(ACC_IDX_CS, 8'h28, 8'h20);
        chk("gate", {7'h0, irq}, 8'h00);
        wr(ACC_IDX_CS, 8'hfb);
        chk("ungate", {7'h0, irq}, 8'h01);
        raw <= 1'b1;
        repeat (6) @(posedge mclk);
        wr(ACC_IDX_CS, 8'h24);
        repeat (3) @(posedge mclk);
        rdm(ACC_IDX_CS, 8'h08, 8'h00);
        chk("off", {7'h0, pinOut}, 8'h00);
        raw <= 1'b0;
        wr(ACC_IDX_CS, 8'h00);
    endtask : t_cs
    task automatic t_sens;
        for (int c = 0; c < 4; c++) begin
            wr(ACC_IDX_CS, 8'h90 | 8'(c));
            raw <= 1'b1;
            repeat (4) @(posedge mclk);
            chk("lag", {7'h0, irq}, 8'h00);
            @(posedge mclk);
            chk("rise", {7'h0, irq}, 8'(c % 2));
            wr(ACC_IDX_CS, 8'h90 | 8'(c));
            raw <= 1'b0;
            repeat (5) @(posedge mclk);
            chk("fall", {7'h0, irq}, 8'(c != 1));
        end
    endtask : t_sens
    task automatic t_istat;
        wr(ACC_IDX_CS, 8'h81);
        wr(ACC_IDX_ICLR, 8'h07);
        wr(ACC_IDX_IEN, 8'h02);
        raw <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("irq", {7'h0, irq}, 8'h01);
        rdm(ACC_IDX_ISTAT, 8'hff, 8'h03);
        wr(ACC_IDX_IEN, 8'h00);
        chk("mask", {7'h0, irq}, 8'h00);
        wr(ACC_IDX_IEN, 8'h02);
        wr(ACC_IDX_ICLR, 8'h02);
        chk("ack", {7'h0, irq}, 8'h00);
        rdm(ACC_IDX_ISTAT, 8'hff, 8'h01);
        rdm(ACC_IDX_ICLR, 8'hff, 8'h00);
    endtask : t_istat
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_regs();
        t_cs();
        t_sens();
        t_istat();
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        stopTest();
    end
endmodule : testbench
